// ### logic/osl_pkg.sv
// Constants shared by the octal serial-load converter logic.
// Assumes a 10 MHz system clock and a host-driven serial clock.
//
// Contract
// - While the load strobe is high each rising serial clock shifts the serial input into a 4-bit address plus 12-bit data register.
// - While the load strobe is high and clocks run the serial output drives valid shift register contents.
// - A falling load strobe copies the 12 data bits into the channel register picked by the shifted address.
// - While the load strobe is low the serial clock and input are ignored and the serial output is high impedance.
// - Addresses with the top bit clear pick channels 0 to 7 from the low three bits; any other address loads nothing.
// - A low preset forces all eight channels to zero volts regardless of strobe, clock, address and data.
// - Channel codes are offset binary over 4096 steps: 000 is negative full scale, 800 is zero, FFF is one step below positive full scale.
// - Preset loads the code with only the data MSB set into every channel register.

package osl_pkg;

    // --------------------------------------------------------------
    // Frame layout
    // --------------------------------------------------------------
    localparam int OSL_ADDR_W = 4;
    localparam int OSL_DATA_W = 12;
    localparam int OSL_FRAME_W = OSL_ADDR_W + OSL_DATA_W;
    localparam int OSL_ADDR_SEL_BIT = 3;
    localparam int OSL_CHANNELS = 8;

    // --------------------------------------------------------------
    // Reset values and synchroniser depth
    // --------------------------------------------------------------
    localparam logic [OSL_FRAME_W-1:0] OSL_FRAME_RESET = 16'h0000;
    localparam logic [OSL_DATA_W-1:0] OSL_ZERO_CODE = 12'h800;
    localparam logic OSL_STROBE_IDLE = 1'h0;
    localparam logic OSL_PRESET_IDLE = 1'h1;
    localparam logic [1:0] OSL_RSYNC_RESET = 2'h3;

endpackage

// ### logic/osl_sync.sv
// Three-flop synchroniser with a two-of-two agreement filter.
// Assumes the input is asynchronous to CLK; output is registered.
`timescale 1ns/1ns

module osl_sync
    import osl_pkg::*;
#(
    parameter logic RESET_VAL = 1'h0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Asynchronous level in, filtered level out
    input wire logic async_in,
    output logic level
);

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } osl_sync_state_type;

    osl_sync_state_type st_reg;
    osl_sync_state_type st_next;

    // ----------------------------------------------------------
    // Next state
    // ----------------------------------------------------------
    // The first stage feeds only the second; a change counts once the
    // second and third stages agree, so a single-stage glitch is lost.
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
        if (srst) begin
            st_next = {4{RESET_VAL}};
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign level = st_reg.level;

endmodule

// ### logic/osl_top.sv
// Serial load logic of an eight-channel 12-bit converter.
// Assumes the host drives strobe and data synchronous to SERIAL_CLK.
`timescale 1ns/1ns

module osl_top
    import osl_pkg::*;
#(
    parameter int DATA_W = OSL_DATA_W
) (
    // System clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Serial port from the host
    input wire logic SERIAL_CLK,
    input wire logic LOAD_STROBE_N,
    input wire logic SERIAL_IN,
    input wire logic PRESET_N,
    // Three-state serial output
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE,
    // Channel codes
    output logic [DATA_W-1:0] CHANNEL0_OUT,
    output logic [DATA_W-1:0] CHANNEL1_OUT,
    output logic [DATA_W-1:0] CHANNEL2_OUT,
    output logic [DATA_W-1:0] CHANNEL3_OUT,
    output logic [DATA_W-1:0] CHANNEL4_OUT,
    output logic [DATA_W-1:0] CHANNEL5_OUT,
    output logic [DATA_W-1:0] CHANNEL6_OUT,
    output logic [DATA_W-1:0] CHANNEL7_OUT
);

    localparam int FRAME_W = OSL_ADDR_W + DATA_W;

    // ----------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------
    if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
        $error("osl_top: DATA_W must lie between 2 and 16");
    end

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    // Mid-scale code: only the data MSB set, which is zero volts
    function automatic logic [DATA_W-1:0] mid_code();
        logic [DATA_W-1:0] c;
        c = '0;
        c[DATA_W-1] = 1'b1;
        return c;
    endfunction

    // Address selects a channel only with its top bit clear
    function automatic logic addr_hits(input logic [OSL_ADDR_W-1:0] a);
        return ~a[OSL_ADDR_SEL_BIT];
    endfunction

    function automatic logic [2:0] addr_chan(input logic [OSL_ADDR_W-1:0] a);
        return a[2:0];
    endfunction

    // ----------------------------------------------------------
    // Link domain: shift register on the serial clock
    // ----------------------------------------------------------
    typedef struct packed {
        logic [1:0] rsync;
        logic [FRAME_W-1:0] sr;
    } osl_link_state_type;

    osl_link_state_type lk_reg;
    osl_link_state_type lk_next;
    logic lk_rst;

    assign lk_rst = lk_reg.rsync[1];

    // The strobe is sampled right on the serial clock, not synchronised:
    // the host sets it up against that clock, and a synchroniser would
    // let the first bits after the strobe rises slip.
    always_comb begin
        lk_next = lk_reg;
        lk_next.rsync = {lk_reg.rsync[0], SRST};
        if (lk_rst) begin
            lk_next.sr = FRAME_W'(OSL_FRAME_RESET);
        end else if (LOAD_STROBE_N) begin
            lk_next.sr = {lk_reg.sr[FRAME_W-2:0], SERIAL_IN};
        end
        // Strobe low: the register holds, the clock has no effect
    end

    always_ff @(posedge SERIAL_CLK) begin
        lk_reg <= lk_next;
    end

    // Far end of the register drives the pin straight from its flop
    assign SERIAL_OUT = lk_reg.sr[FRAME_W-1];

    // ----------------------------------------------------------
    // System domain: pin synchronisers
    // ----------------------------------------------------------
    logic strobe_lvl;
    logic preset_lvl;

    osl_sync #(
        .RESET_VAL(OSL_STROBE_IDLE)
    ) u_sync_strobe (
        .clk(CLK),
        .srst(SRST),
        .async_in(LOAD_STROBE_N),
        .level(strobe_lvl)
    );

    osl_sync #(
        .RESET_VAL(OSL_PRESET_IDLE)
    ) u_sync_preset (
        .clk(CLK),
        .srst(SRST),
        .async_in(PRESET_N),
        .level(preset_lvl)
    );

    // ----------------------------------------------------------
    // System domain: channel registers
    // ----------------------------------------------------------
    typedef struct packed {
        logic strobe_prev;
        logic oe;
        logic [OSL_CHANNELS-1:0][DATA_W-1:0] chan;
    } osl_sys_state_type;

    osl_sys_state_type sy_reg;
    osl_sys_state_type sy_next;
    logic load_evt;
    logic [OSL_ADDR_W-1:0] frame_addr;
    logic [DATA_W-1:0] frame_data;

    assign load_evt = sy_reg.strobe_prev & ~strobe_lvl;
    // Read across domains only while the strobe is low: shifting is
    // frozen then and the frame has been still for several CLK cycles.
    assign frame_addr = lk_reg.sr[FRAME_W-1 -: OSL_ADDR_W];
    assign frame_data = lk_reg.sr[DATA_W-1:0];

    always_comb begin
        sy_next = sy_reg;
        sy_next.strobe_prev = strobe_lvl;
        sy_next.oe = strobe_lvl;
        if (load_evt && addr_hits(frame_addr)) begin
            sy_next.chan[addr_chan(frame_addr)] = frame_data;
        end
        // Preset overrides any load in the same cycle
        if (!preset_lvl) begin
            for (int i = 0; i < OSL_CHANNELS; i++) begin
                sy_next.chan[i] = mid_code();
            end
        end
        if (SRST) begin
            sy_next.strobe_prev = OSL_STROBE_IDLE;
            sy_next.oe = 1'b0;
            for (int i = 0; i < OSL_CHANNELS; i++) begin
                sy_next.chan[i] = mid_code();
            end
        end
    end

    always_ff @(posedge CLK) begin
        sy_reg <= sy_next;
    end

    // ----------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------
    assign SERIAL_OUT_OE = sy_reg.oe;
    assign CHANNEL0_OUT = sy_reg.chan[0];
    assign CHANNEL1_OUT = sy_reg.chan[1];
    assign CHANNEL2_OUT = sy_reg.chan[2];
    assign CHANNEL3_OUT = sy_reg.chan[3];
    assign CHANNEL4_OUT = sy_reg.chan[4];
    assign CHANNEL5_OUT = sy_reg.chan[5];
    assign CHANNEL6_OUT = sy_reg.chan[6];
    assign CHANNEL7_OUT = sy_reg.chan[7];

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    chk_shift_in: assert property (
        @(posedge SERIAL_CLK) disable iff (lk_rst)
        (LOAD_STROBE_N && !SRST && !lk_rst && !lk_reg.rsync[0])
        |=> lk_reg.sr == {$past(lk_reg.sr[FRAME_W-2:0]), $past(SERIAL_IN)})
        else $error("shift register did not take the serial input");

    chk_shift_freeze: assert property (
        @(posedge SERIAL_CLK) disable iff (lk_rst)
        (!LOAD_STROBE_N && !SRST && !lk_rst && !lk_reg.rsync[0])
        |=> $stable(lk_reg.sr))
        else $error("shift register moved while strobe low");

    chk_out_order: assert property (
        @(posedge SERIAL_CLK) disable iff (lk_rst)
        (LOAD_STROBE_N && !SRST && !lk_rst && !lk_reg.rsync[0])
        |=> SERIAL_OUT == $past(lk_reg.sr[FRAME_W-2]))
        else $error("serial output is not the far end bit");

    chk_oe_drive: assert property (
        @(posedge CLK) disable iff (SRST)
        $rose(strobe_lvl) |=> SERIAL_OUT_OE [*1] ##1 (SERIAL_OUT_OE
            || !strobe_lvl))
        else $error("serial output not enabled with strobe high");

    chk_hiz_low: assert property (
        @(posedge CLK) disable iff (SRST)
        !strobe_lvl |=> !SERIAL_OUT_OE)
        else $error("serial output driven while strobe low");

    chk_load_chan: assert property (
        @(posedge CLK) disable iff (SRST)
        (load_evt && addr_hits(frame_addr) && preset_lvl)
        |=> sy_reg.chan[$past(frame_addr[2:0])] == $past(frame_data))
        else $error("addressed channel did not load");

    chk_no_load: assert property (
        @(posedge CLK) disable iff (SRST)
        (load_evt && frame_addr[OSL_ADDR_SEL_BIT] && preset_lvl)
        |=> $stable(sy_reg.chan))
        else $error("channel changed on an unmapped address");

    chk_preset_mid: assert property (
        @(posedge CLK) disable iff (SRST)
        !preset_lvl |=> (CHANNEL0_OUT == mid_code()
            && CHANNEL3_OUT == mid_code() && CHANNEL7_OUT == mid_code()))
        else $error("preset did not force the zero code");

    chk_reset_mid: assert property (
        @(posedge CLK)
        SRST |=> (sy_reg.chan == {OSL_CHANNELS{mid_code()}}
            && !SERIAL_OUT_OE))
        else $error("reset did not leave channels at zero code");

    chk_zero_code: assert property (
        @(posedge CLK)
        (SRST || !preset_lvl) |=> (DATA_W != OSL_DATA_W
            || CHANNEL4_OUT == DATA_W'(OSL_ZERO_CODE)))
        else $error("zero-volt code is not 800");

endmodule

// ### dv/osl_host_model.sv
// Host model that drives the four-wire serial port of the converter.
// Assumes the bench resolves the three-state serial output into sdo_pin.
`timescale 1ns/1ns

module osl_host_model (
    // Serial port towards the device
    output logic serial_clk,
    output logic load_strobe_n,
    output logic serial_in,
    // Serial output as seen on the pin
    input wire logic sdo_pin
);
    // ------------------------------------------------------------
    // Idle state: clock parked high so a strobe fall is always legal
    // ------------------------------------------------------------
    initial begin
        serial_clk = 1'b1;
        load_strobe_n = 1'b0;
        serial_in = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame and free clocking tasks
    // ------------------------------------------------------------
    // Strobe is raised well ahead so the synchronised level and OE settle
    task automatic frame(input logic [15:0] w, output logic [15:0] rb);
        load_strobe_n = 1'b1;
        #600;
        for (int i = 15; i >= 0; i--) begin
            rb[i] = sdo_pin;
            serial_clk = 1'b0;
            serial_in = w[i];
            #16;
            serial_clk = 1'b1;
            #16;
        end
        // Data line left showing the inverse so a stale bit cannot pass
        serial_in = ~serial_in;
        load_strobe_n = 1'b0;
        #1000;
    endtask

    // Toggles the clock with changing data, strobe left as it is
    task automatic clocks(input int n);
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b0;
            serial_in = ~serial_in;
            #16;
            serial_clk = 1'b1;
            #16;
        end
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the octal serial-load converter logic.
// Assumes osl_pkg and osl_top are compiled first; host is a model.
`timescale 1ns/1ns

module tb_top;
    import osl_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic preset_n = 1'b1;
    wire logic sclk, strobe_n, sin, sout, oe, sdo_pin;
    wire logic [11:0] c0, c1, c2, c3, c4, c5, c6, c7;
    wire logic [95:0] chs = {c7, c6, c5, c4, c3, c2, c1, c0};
    logic [11:0] exp_ch [8];
    logic [15:0] last_word = 16'h0000;
    logic [15:0] rb;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    assign sdo_pin = oe ? sout : 1'bz;

    osl_top dut (.CLK(clk), .SRST(srst), .SERIAL_CLK(sclk),
        .LOAD_STROBE_N(strobe_n), .SERIAL_IN(sin), .PRESET_N(preset_n),
        .SERIAL_OUT(sout), .SERIAL_OUT_OE(oe), .CHANNEL0_OUT(c0),
        .CHANNEL1_OUT(c1), .CHANNEL2_OUT(c2), .CHANNEL3_OUT(c3),
        .CHANNEL4_OUT(c4), .CHANNEL5_OUT(c5), .CHANNEL6_OUT(c6),
        .CHANNEL7_OUT(c7));
    osl_host_model host (.serial_clk(sclk), .load_strobe_n(strobe_n),
        .serial_in(sin), .sdo_pin(sdo_pin));

    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs about 440 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------
    task automatic cmp_chans;
        for (int n = 0; n < 8; n++) begin
            checks++;
            if (chs[n*12 +: 12] !== exp_ch[n]) begin
                fails++;
                $display("wrong value at %0t: channel %0d", $time, n);
            end
        end
    endtask

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
        checks++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, got, want);
        end
    endtask

    // One frame; readback shows the previous word, pin floats after load
    task automatic send(input logic [3:0] a, input logic [11:0] d);
        host.frame({a, d}, rb);
        cmp_word(rb, last_word);
        last_word = {a, d};
        if (!a[3] && preset_n) begin
            exp_ch[a[2:0]] = d;
        end
        cmp_chans();
        cmp_word({15'h0000, sdo_pin}, {15'h0000, 1'bz});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int n = 0; n < 8; n++) begin
            exp_ch[n] = 12'h800;
        end
        cmp_chans();
    endtask

    task automatic t_channels;
        logic [11:0] codes [8];
        codes = '{12'h000, 12'hFFF, 12'h800, 12'h7FF,
            12'h801, 12'h5A3, 12'hA5C, 12'h123};
        for (int n = 0; n < 8; n++) begin
            send(n[3:0], codes[n]);
        end
    endtask

    task automatic t_unmapped;
        for (int a = 8; a < 16; a++) begin
            send(a[3:0], 12'h3C3 ^ 12'(a));
        end
    endtask

    task automatic t_ignore;
        host.clocks(16);
        send(4'h2, 12'hABC);
    endtask

    task automatic t_preset;
        @(negedge clk) preset_n = 1'b0;
        for (int n = 0; n < 8; n++) begin
            exp_ch[n] = 12'h800;
        end
        repeat (8) @(negedge clk);
        cmp_chans();
        send(4'h1, 12'h456);
        @(negedge clk) preset_n = 1'b1;
        repeat (8) @(negedge clk);
        send(4'h1, 12'h9E7);
    endtask

    initial begin
        fork
            host.clocks(4);
            repeat (8) @(negedge clk);
        join
        srst = 1'b0;
        // Link reset only lets go after serial clock edges with SRST low
        fork
            host.clocks(4);
            repeat (6) @(negedge clk);
        join
        t_reset();
        t_channels();
        t_unmapped();
        t_ignore();
        t_preset();
        print_verdict();
    end
endmodule
